/* File: hw/opsr_device.sv */
// Functional notes
// - Commands decode only while select is sampled low; select high ignores everything.
// - One byte per link clock edge, both edges sampled.
// - 150 us self-initialisation after power; host holds select high, clock low.
// - Reset pin returns all mode registers to defaults; array contents may be lost.
// - Instruction FF over four clocked select-low cycles resets registers; accepted whenever the device is ready.
// - Array bursts default to 32-byte hybrid wrap after reset.
// - Instruction on first rising edge; four address bytes on edges three to six.
// - Decode read, write, linear, register read/write and global reset instruction codes.
// - Address bytes carry upper row, then row/column, then column; top byte, sent first, reserved.
// - Read drives strobe low from edge seven, data after read latency.
// - Variable latency allows up to double delay; first strobe rise marks data.
// - Row crossing bit with linear read continues into the next row.
// - Write bytes with mask sampled high are discarded.
// - Register writes have latency one; register reads use the read latency code.
// - Register read returns the indexed register as first data byte.
// - Registers 0, 4, 8 read/write; 1, 2, 3 read-only; 6 write-only.
// - Register 0 holds latency type, read latency code and drive strength.
// - Read latency codes 0 to 6 give counts 3 to 9; fixed doubles.
// - Writing F0 or C0 to register 6 arms sleep or power down on select high.
// - Burst register selects wrap length 16/32/64/1K and hybrid wrap.
// - Linear instructions use a 1K wrap within the page.
module opsr_device #(
	parameter int         MEM_AW            = 23,
	parameter logic [4:0] VENDOR_ID         = 5'h15, // Arbitrary value.
	parameter logic       ULP_SUPPORT       = 1'b1,
	parameter logic       ROW_CROSS_CAPABLE = 1'b1
) (
	input  wire logic       ref_clk,
	input  wire logic       reset_n,
	input  wire logic       select_n,
	input  wire logic       link_clk,
	input  wire logic [7:0] dq_in,
	output logic      [7:0] dq_out,
	output logic            dq_oe,
	input  wire logic       strobe_mask_in,
	output logic            strobe_mask_out,
	output logic            strobe_mask_oe,
	output logic            ready,
	output logic            hybrid_sleep,
	output logic            deep_powerdown
);

	// ==========================================================================
	// Reset release and pin synchronisers
	logic        rst_meta_r;
	logic        rst_n_r;
	logic [10:0] pin_meta_r;
	logic [10:0] pin_sync_r;
	logic        link_prev_r;
	logic        sel_prev_r;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta_r <= 1'b0;
			rst_n_r    <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n_r    <= rst_meta_r;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			pin_meta_r  <= 11'h401;
			pin_sync_r  <= 11'h401;
			link_prev_r <= 1'b0;
			sel_prev_r  <= 1'b1;
		end else begin
			pin_meta_r  <= {select_n, strobe_mask_in, link_clk, dq_in};
			pin_sync_r  <= pin_meta_r;
			link_prev_r <= pin_sync_r[8];
			sel_prev_r  <= pin_sync_r[10];
		end
	end

	logic       sel_s;
	logic       mask_s;
	logic [7:0] dq_s;
	logic       link_rise;
	logic       link_edge;
	logic       sel_fall;
	logic       sel_rise;

	assign sel_s     = pin_sync_r[10];
	assign mask_s    = pin_sync_r[9];
	assign dq_s      = pin_sync_r[7:0];
	assign link_rise = pin_sync_r[8] & ~link_prev_r;
	assign link_edge = (pin_sync_r[8] ^ link_prev_r) & ~sel_s;
	assign sel_fall  = sel_prev_r & ~sel_s;
	assign sel_rise  = ~sel_prev_r & sel_s;

	// ==========================================================================
	// Power phase
	opsr_pkg::opsr_phase_e phase_r;
	logic [11:0]           init_cnt_r;
	logic [7:0]            lp_arm_r;
	logic                  frame_en_r;
	logic                  regs_default;
	logic                  grst_hit;
	logic [5:0]            edge_cnt_r;
	logic [7:0]            instr_r;

	assign grst_hit = sel_rise & frame_en_r & (instr_r == opsr_pkg::CMD_GLOBAL_RST)
	                & (edge_cnt_r >= opsr_pkg::GRST_MIN_EDGES);

	always_ff @(posedge ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			phase_r    <= opsr_pkg::PH_INIT;
			init_cnt_r <= 12'h000;
		end else begin
			case (phase_r)
				opsr_pkg::PH_INIT: begin
					if (init_cnt_r == 12'(opsr_pkg::INIT_CYCLES - 1)) begin
						phase_r <= opsr_pkg::PH_READY;
					end else begin
						init_cnt_r <= init_cnt_r + 12'h001;
					end
				end
				opsr_pkg::PH_READY: begin
					if (sel_rise && frame_en_r && lp_arm_r == opsr_pkg::LP_HYBRID) begin
						phase_r <= opsr_pkg::PH_HSLEEP;
					end else if (sel_rise && frame_en_r && lp_arm_r == opsr_pkg::LP_DEEP_PD) begin
						phase_r <= opsr_pkg::PH_DPD;
					end
				end
				opsr_pkg::PH_HSLEEP, opsr_pkg::PH_DPD: begin
					if (sel_fall) begin
						phase_r <= opsr_pkg::PH_READY;
					end
				end
				default: phase_r <= opsr_pkg::PH_INIT;
			endcase
		end
	end

	assign regs_default = grst_hit | (sel_fall & (phase_r == opsr_pkg::PH_DPD));

	always_ff @(posedge ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			ready          <= 1'b0;
			hybrid_sleep   <= 1'b0;
			deep_powerdown <= 1'b0;
		end else begin
			ready          <= (phase_r == opsr_pkg::PH_READY);
			hybrid_sleep   <= (phase_r == opsr_pkg::PH_HSLEEP);
			deep_powerdown <= (phase_r == opsr_pkg::PH_DPD);
		end
	end

	// ==========================================================================
	// Frame decode: edge count, instruction and address
	logic [5:0]         cnt_now;
	logic [23:0]        addr_sh_r;
	logic [7:0]         reg_idx_r;
	logic               is_read_r;
	logic               is_write_r;
	logic               is_reg_r;
	logic               is_linear_r;
	logic [5:0]         data_edge_r;
	logic [MEM_AW-1:0]  cur_addr_r;
	logic [MEM_AW-1:0]  addr_nxt;
	logic [9:0]         byte_cnt_r;
	logic               wrap_on_r;
	logic               in_data;
	logic               addr_done;
	logic [7:0]         latency_drive_config_r;
	logic [7:0]         write_latency_refresh_r;
	logic [7:0]         burst_config_r;

	assign cnt_now   = (edge_cnt_r == opsr_pkg::EDGE_MAX) ? edge_cnt_r : edge_cnt_r + 6'h01;
	assign addr_done = link_edge & frame_en_r & (cnt_now == opsr_pkg::EDGE_ADDR_LAST);
	assign in_data   = link_edge & frame_en_r & (edge_cnt_r >= opsr_pkg::EDGE_ADDR_LAST)
	                 & (cnt_now >= data_edge_r);

	function automatic logic [4:0] read_latency(input logic [7:0] cfg);
		logic [2:0] code;
		logic [4:0] lc;
		code = cfg[opsr_pkg::RLC_LSB +: 3];
		if (code > opsr_pkg::RLC_MAX) begin
			code = opsr_pkg::RLC_DEFAULT;
		end
		lc = opsr_pkg::LATENCY_BASE + {2'b00, code};
		return cfg[opsr_pkg::LT_BIT] ? {lc[3:0], 1'b0} : lc;
	endfunction : read_latency

	function automatic logic [4:0] write_latency(input logic [2:0] code);
		case (code)
			3'h0:    return 5'h03;
			3'h4:    return 5'h04;
			3'h2:    return 5'h05;
			3'h6:    return 5'h06;
			3'h1:    return 5'h07;
			3'h5:    return 5'h08;
			3'h3:    return 5'h09;
			default: return 5'h03;
		endcase
	endfunction : write_latency

	logic [4:0] lat_sel;

	always_comb begin
		if (is_reg_r && is_write_r) begin
			lat_sel = opsr_pkg::REG_WR_LATENCY;
		end else if (is_write_r) begin
			lat_sel = write_latency(write_latency_refresh_r[opsr_pkg::WLC_LSB +: 3]);
		end else begin
			lat_sel = read_latency(latency_drive_config_r);
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			frame_en_r  <= 1'b0;
			edge_cnt_r  <= 6'h00;
			instr_r     <= 8'h00;
			addr_sh_r   <= 24'h000000;
			reg_idx_r   <= 8'h00;
			is_read_r   <= 1'b0;
			is_write_r  <= 1'b0;
			is_reg_r    <= 1'b0;
			is_linear_r <= 1'b0;
			data_edge_r <= opsr_pkg::EDGE_MAX;
		end else if (sel_s) begin
			frame_en_r <= 1'b0;
		end else if (sel_fall) begin
			frame_en_r <= (phase_r == opsr_pkg::PH_READY);
			edge_cnt_r <= 6'h00;
			is_read_r  <= 1'b0;
			is_write_r <= 1'b0;
		end else if (link_edge && frame_en_r) begin
			edge_cnt_r <= cnt_now;
			if (cnt_now == opsr_pkg::EDGE_INSTR && link_rise) begin
				instr_r     <= dq_s;
				is_read_r   <= dq_s == opsr_pkg::CMD_SYNC_RD || dq_s == opsr_pkg::CMD_LIN_RD
				            || dq_s == opsr_pkg::CMD_REG_RD;
				is_write_r  <= dq_s == opsr_pkg::CMD_SYNC_WR || dq_s == opsr_pkg::CMD_LIN_WR
				            || dq_s == opsr_pkg::CMD_REG_WR;
				is_reg_r    <= dq_s == opsr_pkg::CMD_REG_RD || dq_s == opsr_pkg::CMD_REG_WR;
				is_linear_r <= dq_s == opsr_pkg::CMD_LIN_RD || dq_s == opsr_pkg::CMD_LIN_WR;
			end else if (cnt_now > opsr_pkg::EDGE_INSTR + 6'h01 && cnt_now <= opsr_pkg::EDGE_ADDR_LAST) begin
				addr_sh_r <= {addr_sh_r[15:0], dq_s};
			end
			if (addr_done) begin
				reg_idx_r   <= dq_s;
				data_edge_r <= {lat_sel + opsr_pkg::CMD_CYCLES, 1'b1};
			end
		end
	end

	// ==========================================================================
	// Burst address sequencing
	logic [9:0] wrap_mask;
	logic [9:0] col;
	logic       hybrid;
	logic       row_cross;

	assign col       = cur_addr_r[9:0];
	assign hybrid    = burst_config_r[opsr_pkg::HYB_BIT] & ~is_linear_r;
	assign row_cross = is_linear_r & is_read_r & burst_config_r[opsr_pkg::RBX_BIT] & ROW_CROSS_CAPABLE;

	always_comb begin
		if (is_linear_r) begin
			wrap_mask = opsr_pkg::WRAP_MASK_1K;
		end else begin
			case (burst_config_r[opsr_pkg::BL_LSB +: 2])
				2'h0:    wrap_mask = opsr_pkg::WRAP_MASK_16;
				2'h1:    wrap_mask = opsr_pkg::WRAP_MASK_32;
				2'h2:    wrap_mask = opsr_pkg::WRAP_MASK_64;
				default: wrap_mask = opsr_pkg::WRAP_MASK_1K;
			endcase
		end
		addr_nxt = cur_addr_r;
		if (row_cross) begin
			addr_nxt = cur_addr_r + MEM_AW'(1);
		end else if (wrap_on_r && hybrid && byte_cnt_r == wrap_mask) begin
			addr_nxt[9:0] = (col & ~wrap_mask) + wrap_mask + 10'h001;
		end else if (wrap_on_r) begin
			addr_nxt[9:0] = (col & ~wrap_mask) | ((col + 10'h001) & wrap_mask);
		end else begin
			addr_nxt[9:0] = col + 10'h001;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			cur_addr_r <= '0;
			byte_cnt_r <= 10'h000;
			wrap_on_r  <= 1'b1;
		end else if (addr_done) begin
			cur_addr_r <= MEM_AW'({addr_sh_r[14:0], dq_s});
			byte_cnt_r <= 10'h000;
			wrap_on_r  <= 1'b1;
		end else if (in_data && !is_reg_r && (is_read_r || is_write_r)) begin
			cur_addr_r <= addr_nxt;
			byte_cnt_r <= byte_cnt_r + 10'h001;
			if (hybrid && byte_cnt_r == wrap_mask) begin
				wrap_on_r <= 1'b0;
			end
		end
	end

	// ==========================================================================
	// Mode registers
	logic reg_wr;

	assign reg_wr = in_data & is_write_r & is_reg_r & (cnt_now == data_edge_r) & ~mask_s;

	always_ff @(posedge ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			latency_drive_config_r  <= opsr_pkg::LATENCY_DRIVE_RST;
			write_latency_refresh_r <= opsr_pkg::WRITE_LATENCY_RST;
			burst_config_r          <= opsr_pkg::BURST_CONFIG_RST;
			lp_arm_r                <= 8'h00;
		end else if (regs_default) begin
			latency_drive_config_r  <= opsr_pkg::LATENCY_DRIVE_RST;
			write_latency_refresh_r <= opsr_pkg::WRITE_LATENCY_RST;
			burst_config_r          <= opsr_pkg::BURST_CONFIG_RST;
			lp_arm_r                <= 8'h00;
		end else if (reg_wr) begin
			case (reg_idx_r)
				opsr_pkg::IDX_LATENCY_DRIVE: latency_drive_config_r  <= dq_s;
				opsr_pkg::IDX_WRITE_LATENCY: write_latency_refresh_r <= dq_s;
				opsr_pkg::IDX_BURST_CONFIG:  burst_config_r          <= dq_s;
				opsr_pkg::IDX_LOW_POWER:     lp_arm_r                <= dq_s;
				default:                     lp_arm_r                <= lp_arm_r;
			endcase
		end else if (sel_rise) begin
			lp_arm_r <= 8'h00;
		end
	end

	logic [7:0] reg_rd_data;

	always_comb begin
		case (reg_idx_r)
			opsr_pkg::IDX_LATENCY_DRIVE: reg_rd_data = latency_drive_config_r;
			opsr_pkg::IDX_VENDOR_POWER:  reg_rd_data = {ULP_SUPPORT, 2'b00, VENDOR_ID};
			opsr_pkg::IDX_DIE_DENSITY:   reg_rd_data = {opsr_pkg::GOOD_DIE, 2'b00, opsr_pkg::DEV_GENERATION,
			                                            opsr_pkg::DENSITY_64M};
			opsr_pkg::IDX_CAPABILITY:    reg_rd_data = {ROW_CROSS_CAPABLE, opsr_pkg::VDD_IS_3V,
			                                            opsr_pkg::FAST_REFRESH, 5'h00};
			opsr_pkg::IDX_WRITE_LATENCY: reg_rd_data = write_latency_refresh_r;
			opsr_pkg::IDX_BURST_CONFIG:  reg_rd_data = burst_config_r;
			default:                     reg_rd_data = 8'h00;
		endcase
	end

	// ==========================================================================
	// Array
	logic [7:0] mem [0:(1 << MEM_AW) - 1];

	always_ff @(posedge ref_clk) begin
		if (in_data && is_write_r && !is_reg_r && !mask_s) begin
			mem[cur_addr_r] <= dq_s;
		end
	end

	// ==========================================================================
	// Read output drive
	always_ff @(posedge ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			dq_out          <= 8'h00;
			dq_oe           <= 1'b0;
			strobe_mask_out <= 1'b0;
			strobe_mask_oe  <= 1'b0;
		end else if (sel_s || !frame_en_r || !is_read_r) begin
			dq_oe          <= 1'b0;
			strobe_mask_oe <= 1'b0;
		end else if (link_edge) begin
			if (cnt_now == opsr_pkg::EDGE_PREAMBLE) begin
				strobe_mask_oe  <= 1'b1;
				strobe_mask_out <= 1'b0;
			end
			if (in_data) begin
				dq_oe           <= 1'b1;
				dq_out          <= is_reg_r ? reg_rd_data : mem[cur_addr_r];
				strobe_mask_out <= link_rise;
			end
		end
	end

endmodule : opsr_device

/* File: hw/opsr_pkg.sv */
package opsr_pkg;

	// ==========================================================================
	// Timing
	localparam int         INIT_TIME_US   = 150;
	localparam int         REF_CLK_MHZ    = 20;
	localparam int         INIT_CYCLES    = INIT_TIME_US * REF_CLK_MHZ;

	// ==========================================================================
	// Instruction bytes
	localparam logic [7:0] CMD_SYNC_RD    = 8'h00;
	localparam logic [7:0] CMD_SYNC_WR    = 8'h80;
	localparam logic [7:0] CMD_LIN_RD     = 8'h20;
	localparam logic [7:0] CMD_LIN_WR     = 8'hA0;
	localparam logic [7:0] CMD_REG_RD     = 8'h40;
	localparam logic [7:0] CMD_REG_WR     = 8'hC0;
	localparam logic [7:0] CMD_GLOBAL_RST = 8'hFF;

	// ==========================================================================
	// Mode register indexes and reset values
	localparam logic [7:0] IDX_LATENCY_DRIVE = 8'h00;
	localparam logic [7:0] IDX_VENDOR_POWER  = 8'h01;
	localparam logic [7:0] IDX_DIE_DENSITY   = 8'h02;
	localparam logic [7:0] IDX_CAPABILITY    = 8'h03;
	localparam logic [7:0] IDX_WRITE_LATENCY = 8'h04;
	localparam logic [7:0] IDX_LOW_POWER     = 8'h06;
	localparam logic [7:0] IDX_BURST_CONFIG  = 8'h08;
	localparam logic [7:0] LATENCY_DRIVE_RST = 8'h09;
	localparam logic [7:0] WRITE_LATENCY_RST = 8'h00;
	localparam logic [7:0] BURST_CONFIG_RST  = 8'h05;

	// ==========================================================================
	// Field positions and fixed field values
	localparam int         LT_BIT         = 5;
	localparam int         RLC_LSB        = 2;
	localparam int         WLC_LSB        = 5;
	localparam int         RBX_BIT        = 3;
	localparam int         HYB_BIT        = 2;
	localparam int         BL_LSB         = 0;
	localparam logic [2:0] RLC_MAX        = 3'h6;
	localparam logic [2:0] RLC_DEFAULT    = 3'h2;
	localparam logic       GOOD_DIE       = 1'b1;
	localparam logic [1:0] DEV_GENERATION = 2'h2;
	localparam logic [2:0] DENSITY_64M    = 3'h3;
	localparam logic       VDD_IS_3V      = 1'b0;
	localparam logic       FAST_REFRESH   = 1'b1;
	localparam logic [7:0] LP_HYBRID      = 8'hF0;
	localparam logic [7:0] LP_DEEP_PD     = 8'hC0;

	// ==========================================================================
	// Frame edge numbers and latency figures
	localparam logic [5:0] EDGE_INSTR     = 6'h01;
	localparam logic [5:0] EDGE_ADDR_LAST = 6'h06;
	localparam logic [5:0] EDGE_PREAMBLE  = 6'h07;
	localparam logic [5:0] EDGE_MAX       = 6'h3F;
	localparam logic [5:0] GRST_MIN_EDGES = 6'h08;
	localparam logic [4:0] CMD_CYCLES     = 5'h03;
	localparam logic [4:0] LATENCY_BASE   = 5'h03;
	localparam logic [4:0] REG_WR_LATENCY = 5'h01;
	localparam logic [9:0] WRAP_MASK_16   = 10'h00F;
	localparam logic [9:0] WRAP_MASK_32   = 10'h01F;
	localparam logic [9:0] WRAP_MASK_64   = 10'h03F;
	localparam logic [9:0] WRAP_MASK_1K   = 10'h3FF;

	typedef enum logic [1:0] {PH_INIT, PH_READY, PH_HSLEEP, PH_DPD} opsr_phase_e;

endpackage : opsr_pkg

/* File: sim/opsr_device_asserts.sv */
module opsr_device_asserts (
	input wire logic       ref_clk,
	input wire logic       reset_n,
	input wire logic       select_n,
	input wire logic       link_clk,
	input wire logic [7:0] dq_in,
	input wire logic [7:0] dq_out,
	input wire logic       dq_oe,
	input wire logic       strobe_mask_in,
	input wire logic       strobe_mask_out,
	input wire logic       strobe_mask_oe,
	input wire logic       ready,
	input wire logic       hybrid_sleep,
	input wire logic       deep_powerdown
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int INIT_N = opsr_pkg::INIT_CYCLES;
	logic [11:0] init_cnt_r;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	// ==========================================================================
	// Cycles since reset release.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			init_cnt_r <= 12'h000;
		end else if (init_cnt_r != 12'hFFF) begin
			init_cnt_r <= init_cnt_r + 12'h001;
		end
	end
	// ==========================================================================
	// Properties.
	a_idle_dq_off: assert property (select_n [*5] |-> !dq_oe)
		else $error("data bus driven while deselected");
	a_idle_strobe_off: assert property (select_n [*5] |-> !strobe_mask_oe)
		else $error("strobe driven while deselected");
	a_init_not_ready: assert property ((init_cnt_r < INIT_N) |-> !ready)
		else $error("ready before initialisation time");
	a_init_ready_by: assert property ((init_cnt_r == INIT_N + 16) |-> ready)
		else $error("ready late after initialisation");
	a_preamble_low: assert property ($rose(strobe_mask_oe) |-> !strobe_mask_out)
		else $error("strobe preamble not low");
	a_latency_gap: assert property ($rose(strobe_mask_oe) |-> !dq_oe ##1 !dq_oe [*8])
		else $error("data too soon after preamble");
	a_first_rise: assert property ($rose(dq_oe) |-> strobe_mask_out && strobe_mask_oe)
		else $error("first data byte without strobe high");
	a_sleep_ready: assert property (hybrid_sleep |-> !ready && !deep_powerdown)
		else $error("sleep and ready together");
	a_dpd_ready: assert property (deep_powerdown |-> !ready)
		else $error("power down and ready together");
endmodule : opsr_device_asserts

/* File: sim/opsr_host.sv */
module opsr_host (
	input  wire logic       ref_clk,
	output logic            select_n,
	output logic            link_clk,
	output logic      [7:0] dq_in,
	output logic            strobe_mask_in,
	input  wire logic [7:0] dq_out,
	input  wire logic       dq_oe,
	input  wire logic       strobe_mask_out,
	input  wire logic       strobe_mask_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] wd [32];
	logic       wm [32];
	logic [7:0] rd [16];
	logic       rs [16];
	logic [7:0] hdq;
	logic       hmk;
	logic       hoe;
	logic [7:0] junk;
	// Released lines show a changing pattern so a stale value never passes.
	assign dq_in          = dq_oe ? dq_out : (hoe ? hdq : junk);
	assign strobe_mask_in = strobe_mask_oe ? strobe_mask_out : (hoe ? hmk : junk[0]);
	initial begin
		select_n = 1'b1;
		link_clk = 1'b0;
		hdq      = 8'h00;
		hmk      = 1'b0;
		hoe      = 1'b0;
		junk     = 8'h5A;
	end
	always @(posedge ref_clk) begin
		junk <= junk + 8'h3B;
	end
	// ==========================================================================
	// One frame: edge 1 instruction, edges 3 to 6 address, data from edge d.
	task automatic frame(input logic [7:0] cmd, input logic [22:0] a, input int d, input int n, input logic wr);
		int e;
		int t;
		t = d + n - 1;
		@(posedge ref_clk);
		select_n <= 1'b0;
		hoe      <= 1'b1;
		hdq      <= cmd;
		repeat (4) @(posedge ref_clk);
		for (e = 1; e <= t + 1; e++) begin
			if (e <= t) begin
				link_clk <= e[0];
			end
			hdq <= (e == 1) ? cmd : (e == 4) ? {1'b0, a[22:16]} : (e == 5) ? a[15:8] : (e == 6) ? a[7:0]
				: (e >= d && e < d + n) ? wd[e-d] : 8'h00;
			hmk <= (e >= d && e < d + n) ? wm[e-d] : 1'b0;
			hoe <= (e < 7) || (wr && e < d + n);
			repeat (2) @(posedge ref_clk);
			@(negedge ref_clk);
			if (e - 1 >= d && e - 1 < d + n) begin
				rd[e-1-d] = dq_out;
				rs[e-1-d] = strobe_mask_out;
			end
			repeat (2) @(posedge ref_clk);
		end
		select_n <= 1'b1;
		hoe      <= 1'b0;
		repeat (10) @(posedge ref_clk);
	endtask : frame
	task automatic pulse();
		@(posedge ref_clk);
		select_n <= 1'b0;
		repeat (4) @(posedge ref_clk);
		select_n <= 1'b1;
		repeat (10) @(posedge ref_clk);
	endtask : pulse
endmodule : opsr_host

/* File: sim/tb_top.sv */
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic       ref_clk;
	logic       reset_n;
	logic       select_n;
	logic       link_clk;
	logic [7:0] dq_in;
	logic [7:0] dq_out;
	logic       dq_oe;
	logic       strobe_mask_in;
	logic       strobe_mask_out;
	logic       strobe_mask_oe;
	logic       ready;
	logic       hybrid_sleep;
	logic       deep_powerdown;
	int         err_total;
	int         samples_checked;
	logic [7:0] exp_r [7];
	logic [7:0] idx_r [7];
	initial ref_clk = 1'b0;
	always #25 ref_clk = ~ref_clk;
	opsr_device #(.MEM_AW(12), .VENDOR_ID(5'h15)) opsr_device_instruction_byte (
		.ref_clk(ref_clk), .reset_n(reset_n), .select_n(select_n), .link_clk(link_clk), .dq_in(dq_in),
		.dq_out(dq_out), .dq_oe(dq_oe), .strobe_mask_in(strobe_mask_in), .strobe_mask_out(strobe_mask_out),
		.strobe_mask_oe(strobe_mask_oe), .ready(ready), .hybrid_sleep(hybrid_sleep),
		.deep_powerdown(deep_powerdown));
	opsr_host opsr_host_instruction_byte (
		.ref_clk(ref_clk), .select_n(select_n), .link_clk(link_clk), .dq_in(dq_in),
		.strobe_mask_in(strobe_mask_in), .dq_out(dq_out), .dq_oe(dq_oe), .strobe_mask_out(strobe_mask_out),
		.strobe_mask_oe(strobe_mask_oe));
	// ==========================================================================
	// Helpers.
	task automatic report_and_stop();
		if (err_total == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : report_and_stop
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic wait_ready();
		int i;
		for (i = 0; i < 5000 && ready !== 1'b1; i++) @(posedge ref_clk);
		if (ready !== 1'b1) begin
			err_total++;
			report_and_stop();
		end
	endtask : wait_ready
	task automatic regwr(input logic [7:0] idx, input logic [7:0] v);
		opsr_host_instruction_byte.wd[0] = v;
		opsr_host_instruction_byte.wm[0] = 1'b0;
		opsr_host_instruction_byte.frame(opsr_pkg::CMD_REG_WR, {15'h0000, idx}, 9, 2, 1'b1);
	endtask : regwr
	task automatic regrd(input logic [7:0] idx, input int d, input logic [7:0] exp);
		opsr_host_instruction_byte.frame(opsr_pkg::CMD_REG_RD, {15'h0000, idx}, d, 2, 1'b0);
		check("register", opsr_host_instruction_byte.rd[0], exp);
	endtask : regrd
	task automatic arr(input logic [7:0] cmd, input logic [22:0] a, input int n, input logic [7:0] b0);
		int i;
		for (i = 0; i < n; i++) begin
			opsr_host_instruction_byte.wd[i] = b0 + 8'(i);
			opsr_host_instruction_byte.wm[i] = 1'b0;
		end
		opsr_host_instruction_byte.frame(cmd, a, cmd[7] ? 13 : 17, n, cmd[7]);
	endtask : arr
	// ==========================================================================
	// Main sequence.
	initial begin
		err_total       = 0;
		samples_checked = 0;
		reset_n         = 1'b0;
		idx_r = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h08};
		exp_r = '{opsr_pkg::LATENCY_DRIVE_RST, {1'b1, 2'h0, 5'h15},
			{opsr_pkg::GOOD_DIE, 2'h0, opsr_pkg::DEV_GENERATION, opsr_pkg::DENSITY_64M},
			{1'b1, opsr_pkg::VDD_IS_3V, opsr_pkg::FAST_REFRESH, 5'h00},
			opsr_pkg::WRITE_LATENCY_RST, 8'h00, opsr_pkg::BURST_CONFIG_RST};
		repeat (3) @(posedge ref_clk);
		reset_n <= 1'b1;
		wait_ready();
		for (int k = 0; k < 7; k++) regrd(idx_r[k], 17, exp_r[k]);
		check("strobe", {7'h00, opsr_host_instruction_byte.rs[0]}, 8'h01);
		regwr(8'h01, 8'h00);
		regrd(8'h01, 17, exp_r[1]);
		regwr(8'h00, 8'h01);
		regrd(8'h00, 13, 8'h01);
		regwr(8'h00, 8'h21);
		regrd(8'h00, 19, 8'h21);
		opsr_host_instruction_byte.frame(opsr_pkg::CMD_GLOBAL_RST, 23'h000000, 7, 2, 1'b0);
		regrd(8'h00, 17, 8'h09);
		arr(opsr_pkg::CMD_SYNC_WR, 23'h00001C, 8, 8'h30);
		arr(opsr_pkg::CMD_SYNC_RD, 23'h000000, 2, 8'h00);
		for (int k = 0; k < 2; k++) check("default_wrap", opsr_host_instruction_byte.rd[k], 8'h34 + 8'(k));
		regwr(8'h08, 8'h00);
		arr(opsr_pkg::CMD_SYNC_WR, 23'h00000C, 8, 8'h10);
		arr(opsr_pkg::CMD_SYNC_RD, 23'h000000, 4, 8'h00);
		for (int k = 0; k < 4; k++) check("wrap", opsr_host_instruction_byte.rd[k], 8'h14 + 8'(k));
		regwr(8'h04, 8'h80);
		opsr_host_instruction_byte.wd[0] = 8'hAA;
		opsr_host_instruction_byte.wm[0] = 1'b0;
		opsr_host_instruction_byte.wd[1] = 8'hBB;
		opsr_host_instruction_byte.wm[1] = 1'b1;
		opsr_host_instruction_byte.frame(opsr_pkg::CMD_SYNC_WR, 23'h000000, 15, 2, 1'b1);
		regwr(8'h04, 8'h00);
		arr(opsr_pkg::CMD_SYNC_RD, 23'h000000, 2, 8'h00);
		check("unmasked", opsr_host_instruction_byte.rd[0], 8'hAA);
		check("masked", opsr_host_instruction_byte.rd[1], 8'h15);
		arr(opsr_pkg::CMD_LIN_WR, 23'h00000C, 8, 8'h20);
		arr(opsr_pkg::CMD_SYNC_RD, 23'h000010, 4, 8'h00);
		for (int k = 0; k < 4; k++) check("linear", opsr_host_instruction_byte.rd[k], 8'h24 + 8'(k));
		regwr(8'h08, 8'h04);
		arr(opsr_pkg::CMD_SYNC_WR, 23'h000002, 18, 8'h40);
		arr(opsr_pkg::CMD_SYNC_RD, 23'h000010, 2, 8'h00);
		for (int k = 0; k < 2; k++) check("hybrid", opsr_host_instruction_byte.rd[k], 8'h50 + 8'(k));
		regwr(8'h08, 8'h08);
		arr(opsr_pkg::CMD_SYNC_WR, 23'h000400, 2, 8'hC1);
		arr(opsr_pkg::CMD_LIN_WR, 23'h0003FE, 2, 8'hC3);
		arr(opsr_pkg::CMD_LIN_RD, 23'h0003FE, 4, 8'h00);
		check("cross0", opsr_host_instruction_byte.rd[0], 8'hC3);
		check("cross3", opsr_host_instruction_byte.rd[3], 8'hC2);
		for (int k = 0; k < 2; k++) begin
			regwr(8'h00, 8'h01);
			regwr(opsr_pkg::IDX_LOW_POWER, k == 0 ? opsr_pkg::LP_HYBRID : opsr_pkg::LP_DEEP_PD);
			check("sleep", {7'h00, hybrid_sleep}, (k == 0) ? 8'h01 : 8'h00);
			check("powerdown", {7'h00, deep_powerdown}, (k == 1) ? 8'h01 : 8'h00);
			opsr_host_instruction_byte.pulse();
			wait_ready();
			regrd(8'h00, k == 0 ? 13 : 17, k == 0 ? 8'h01 : 8'h09);
		end
		regwr(8'h08, 8'h01);
		regrd(8'h08, 17, 8'h01);
		@(posedge ref_clk);
		reset_n <= 1'b0;
		repeat (3) @(posedge ref_clk);
		reset_n <= 1'b1;
		regwr(8'h08, 8'h01);
		wait_ready();
		regrd(8'h08, 17, 8'h05);
		report_and_stop();
	end
endmodule : tb_top
bind opsr_device opsr_device_asserts opsr_device_asserts_instruction_byte (
	.ref_clk(ref_clk), .reset_n(reset_n), .select_n(select_n), .link_clk(link_clk), .dq_in(dq_in),
	.dq_out(dq_out), .dq_oe(dq_oe), .strobe_mask_in(strobe_mask_in), .strobe_mask_out(strobe_mask_out),
	.strobe_mask_oe(strobe_mask_oe), .ready(ready), .hybrid_sleep(hybrid_sleep),
	.deep_powerdown(deep_powerdown));
